// ### src/lgc_pkg.sv
// Function
// - synthesizer makes E1 clock when rate bit is 0, T1/J1 when 1
// - with mute set, a channel in loss forces its data outputs low; clock runs
// - loss declared after 4096 zeros if extended, else 175 (T1) or 32 (E1)
// - in-circuit-test bit tristates every output, same as test pin low
package lgc_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam logic [6:0] ADDR_GLOBAL = 7'h41;
  localparam logic [6:0] ADDR_TUNING = 7'h42;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // global register bit positions
  localparam int unsigned B_SEL_HI = 5;
  localparam int unsigned B_SEL_LO = 4;
  localparam int unsigned B_RATE = 3;
  localparam int unsigned B_MUTE = 2;
  localparam int unsigned B_EXT = 1;
  localparam int unsigned B_IN_TEST = 0;
  localparam logic [7:0] GLOBAL_MASK = 8'h3f;
  // tuning register bit positions
  localparam int unsigned B_GAUGE_HI = 7;
  localparam int unsigned B_GAUGE_LO = 6;
  localparam int unsigned B_TXON_CTL = 5;
  localparam int unsigned B_TERM_CTL = 4;
  // zero counts before loss is declared
  localparam int unsigned CNT_W = 13;
  localparam logic [12:0] ZEROS_EXT = 13'h1000;
  localparam logic [12:0] ZEROS_T1 = 13'h00af;
  localparam logic [12:0] ZEROS_E1 = 13'h0020;
endpackage : lgc_pkg

// ### src/lgc_los_if.sv
`timescale 1ns/10ps
// settings from the register bank to one loss detector
interface lgc_los_if;
  logic ext_q;
  logic t1_q;
  modport bank (output ext_q, output t1_q);
  modport det (input ext_q, input t1_q);
endinterface : lgc_los_if

// ### src/lgc_los_det.sv
`timescale 1ns/10ps
module lgc_los_det (
  input wire logic i_clk,
  input wire logic i_rst,
  lgc_los_if.det cfg,
  input wire logic i_bit_stb,
  input wire logic i_mark,
  output logic o_los
);
  logic [lgc_pkg::CNT_W-1:0] cnt_q;
  logic [lgc_pkg::CNT_W-1:0] limit;

  // zero count threshold for the current mode
  always_comb begin
    if (cfg.ext_q) begin
      limit = lgc_pkg::ZEROS_EXT;
    end else if (cfg.t1_q) begin
      limit = lgc_pkg::ZEROS_T1;
    end else begin
      limit = lgc_pkg::ZEROS_E1;
    end
  end

  // count consecutive zeros, saturating at the threshold
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (i_bit_stb) begin
      if (i_mark) begin
        cnt_q <= '0;
      end else if (cnt_q < limit) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign o_los = (cnt_q >= limit);
endmodule : lgc_los_det

// ### src/lgc_regs.sv
`timescale 1ns/10ps
module lgc_regs #(
  parameter int unsigned N_CH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [lgc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [lgc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [lgc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_in_circuit_test_n,
  input wire logic [N_CH-1:0] i_rx_stb,
  input wire logic [N_CH-1:0] i_rx_mark,
  input wire logic [N_CH-1:0] i_rx_pos,
  input wire logic [N_CH-1:0] i_rx_neg,
  output logic [N_CH-1:0] o_receive_positive_out,
  output logic [N_CH-1:0] o_line_code_violation_out,
  output logic [N_CH-1:0] o_receive_loss_of_signal,
  output logic o_out_en,
  output logic o_synth_rate_select,
  output logic o_synth_input_select_hi,
  output logic o_synth_input_select_lo,
  output logic o_wire_size_sel_hi,
  output logic o_wire_size_sel_lo,
  output logic o_transmit_enable_pin_ctl,
  output logic o_termination_pin_ctl
);

  // refuse a channel count that the per-channel logic cannot serve
  if (N_CH < 1) begin : g_bad_n_ch
    $error("lgc_regs needs at least one channel");
  end

  // true when the host addresses the given register
  function automatic logic addr_hits(
    input logic [lgc_pkg::ADDR_W-1:0] addr,
    input logic [lgc_pkg::ADDR_W-1:0] target
  );
    return (addr == target);
  endfunction : addr_hits

  // receive data with the per-channel mute applied while in loss
  function automatic logic [N_CH-1:0] mute_apply(
    input logic [N_CH-1:0] data,
    input logic [N_CH-1:0] loss,
    input logic mute
  );
    logic [N_CH-1:0] keep;
    keep = mute ? ~loss : '1;
    return data & keep;
  endfunction : mute_apply

  // register storage and read path
  logic [lgc_pkg::DATA_W-1:0] global_q;
  logic [lgc_pkg::DATA_W-1:0] tuning_q;
  logic [lgc_pkg::DATA_W-1:0] rdata_q;

  // per-channel receive state
  logic [N_CH-1:0] los;
  logic [N_CH-1:0] pos_q;
  logic [N_CH-1:0] neg_q;

  // address decode results
  logic hit_global;
  logic hit_tuning;
  logic wr_global;
  logic wr_tuning;

  // decoded fields of the global register
  logic rate_sel;
  logic mute_en;
  logic ext_en;
  logic test_en;
  logic sel_hi;
  logic sel_lo;

  // decoded fields of the tuning register
  logic gauge_hi;
  logic gauge_lo;
  logic txon_ctl;
  logic term_ctl;

  // address decode shared by the write and read paths
  assign hit_global = addr_hits(i_addr, lgc_pkg::ADDR_GLOBAL);
  assign hit_tuning = addr_hits(i_addr, lgc_pkg::ADDR_TUNING);
  assign wr_global = i_wr & hit_global;
  assign wr_tuning = i_wr & hit_tuning;

  // global register; unused top bits are masked so they always read zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      global_q <= lgc_pkg::RESET_VAL;
    end else if (wr_global) begin
      global_q <= i_wdata & lgc_pkg::GLOBAL_MASK;
    end
  end

  // tuning register; the low slicer and equalizer bits are only stored here
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tuning_q <= lgc_pkg::RESET_VAL;
    end else if (wr_tuning) begin
      tuning_q <= i_wdata;
    end
  end

  // read data registered; a write in the same cycle shows on the next read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= lgc_pkg::RESET_VAL;
    end else if (i_rd) begin
      if (hit_global) begin
        rdata_q <= global_q;
      end else if (hit_tuning) begin
        rdata_q <= tuning_q;
      end else begin
        rdata_q <= '0; // unmapped addresses read as zero
      end
    end
  end

  // read data leaves straight from its flip-flops
  assign o_rdata = rdata_q;

  // global fields, split out once so every consumer sees the same bit
  assign rate_sel = global_q[lgc_pkg::B_RATE];
  assign mute_en = global_q[lgc_pkg::B_MUTE];
  assign ext_en = global_q[lgc_pkg::B_EXT];
  assign test_en = global_q[lgc_pkg::B_IN_TEST];
  assign sel_hi = global_q[lgc_pkg::B_SEL_HI];
  assign sel_lo = global_q[lgc_pkg::B_SEL_LO];

  // tuning fields
  assign gauge_hi = tuning_q[lgc_pkg::B_GAUGE_HI];
  assign gauge_lo = tuning_q[lgc_pkg::B_GAUGE_LO];
  assign txon_ctl = tuning_q[lgc_pkg::B_TXON_CTL];
  assign term_ctl = tuning_q[lgc_pkg::B_TERM_CTL];

  // one loss detector per channel, all sharing the global mode bits
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    lgc_los_if cfg_if ();

    // a mode change reaches the loss flag in the cycle after the write, without waiting for a received bit
    assign cfg_if.ext_q = ext_en;
    assign cfg_if.t1_q = rate_sel;

    lgc_los_det u_det (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .cfg(cfg_if),
      .i_bit_stb(i_rx_stb[c]),
      .i_mark(i_rx_mark[c]),
      .o_los(los[c])
    );
  end

  // positive data output, forced low per channel while muted and in loss
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_q <= '0;
    end else begin
      pos_q <= mute_apply(i_rx_pos, los, mute_en);
    end
  end

  // violation output, muted the same way; the recovered clock is left alone
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      neg_q <= '0;
    end else begin
      neg_q <= mute_apply(i_rx_neg, los, mute_en);
    end
  end

  // receive outputs and loss flags
  assign o_receive_positive_out = pos_q;
  assign o_line_code_violation_out = neg_q;
  assign o_receive_loss_of_signal = los;

  // drive enable for every output pin; either the bit or the pin floats them
  assign o_out_en = ~test_en & i_in_circuit_test_n;

  // clock synthesizer controls
  assign o_synth_rate_select = rate_sel;
  assign o_synth_input_select_hi = sel_hi;
  assign o_synth_input_select_lo = sel_lo;

  // line tuning controls
  assign o_wire_size_sel_hi = gauge_hi;
  assign o_wire_size_sel_lo = gauge_lo;
  assign o_transmit_enable_pin_ctl = txon_ctl;
  assign o_termination_pin_ctl = term_ctl;
endmodule : lgc_regs

// ### verif/lgc_regs_monitor.sv
`timescale 1ns/10ps
module lgc_regs_monitor #(
  parameter int unsigned N_CH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [lgc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [lgc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [lgc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_in_circuit_test_n,
  input wire logic [N_CH-1:0] i_rx_stb,
  input wire logic [N_CH-1:0] i_rx_mark,
  input wire logic [N_CH-1:0] o_receive_positive_out,
  input wire logic [N_CH-1:0] o_line_code_violation_out,
  input wire logic [N_CH-1:0] o_receive_loss_of_signal,
  input wire logic o_out_en,
  input wire logic o_synth_rate_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] g_q;
  // shadow of the global register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) g_q <= 8'h00;
    else if (i_wr && i_addr == lgc_pkg::ADDR_GLOBAL) g_q <= i_wdata;
  end
  chk_rate_after_wr: assert property (i_wr && i_addr == lgc_pkg::ADDR_GLOBAL |=>
    o_synth_rate_select == $past(i_wdata[3])) else $error("rate select wrong");
  chk_mute_on_loss: assert property (g_q[2] && o_receive_loss_of_signal[0] |=>
    !o_receive_positive_out[0] && !o_line_code_violation_out[0]) else $error("mute failed");
  chk_loss_clears: assert property (i_rx_stb[0] && i_rx_mark[0] |=>
    !o_receive_loss_of_signal[0]) else $error("loss not cleared");
  chk_test_tristate: assert property (o_out_en == (i_in_circuit_test_n && !g_q[0]))
    else $error("output enable wrong");
  chk_global_read: assert property (i_rd && !i_wr && i_addr == lgc_pkg::ADDR_GLOBAL |=>
    o_rdata == (g_q & lgc_pkg::GLOBAL_MASK)) else $error("read data wrong");
  cover property (o_receive_loss_of_signal[0]);
  cover property (g_q[2] && o_receive_loss_of_signal[0]);
  cover property (!o_out_en);
endmodule : lgc_regs_monitor
bind lgc_regs lgc_regs_monitor #(.N_CH(N_CH)) u_mon (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_in_circuit_test_n, .i_rx_stb, .i_rx_mark, .o_receive_positive_out,
  .o_line_code_violation_out, .o_receive_loss_of_signal, .o_out_en, .o_synth_rate_select);

// ### verif/tb_lgc_regs.sv
`timescale 1ns/10ps
module tb_lgc_regs;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_in_circuit_test_n = 1;
  logic o_en, o_r, o_h, o_l;
  logic [6:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata;
  logic [3:0] i_rx_stb = 0, i_rx_mark = 0, i_rx_pos = 0, i_rx_neg = 0, o_p, o_v, o_los;
  logic o_gh, o_gl, o_tx, o_tm;
  int n_mismatch = 0, checks = 0;
  lgc_regs uut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_in_circuit_test_n, .i_rx_stb, .i_rx_mark, .i_rx_pos, .i_rx_neg,
    .o_receive_positive_out(o_p),
    .o_line_code_violation_out(o_v), .o_receive_loss_of_signal(o_los), .o_out_en(o_en),
    .o_synth_rate_select(o_r), .o_synth_input_select_hi(o_h), .o_synth_input_select_lo(o_l),
    .o_wire_size_sel_hi(o_gh), .o_wire_size_sel_lo(o_gl), .o_transmit_enable_pin_ctl(o_tx),
    .o_termination_pin_ctl(o_tm));
  always #20 i_clk = ~i_clk;
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(negedge i_clk) {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
    @(negedge i_clk) i_wr = 0;
  endtask : wr
  task automatic rdc(logic [6:0] a, logic [7:0] e);
    @(negedge i_clk) {i_addr, i_rd} = {a, 1'b1};
    @(negedge i_clk) i_rd = 0;
    cmp("rdata", e, o_rdata);
  endtask : rdc
  // feed n bits of one value to every channel
  task automatic bits(int n, logic m);
    repeat (n) begin
      @(negedge i_clk) {i_rx_stb, i_rx_mark} = {4'hf, {4{m}}};
      @(negedge i_clk) i_rx_stb = 0;
    end
  endtask : bits
  task automatic t_regs;
    rdc(7'h41, 8'h00);
    rdc(7'h42, 8'h00);
    cmp("outs", 8'h00, {o_gh, o_gl, o_tx, o_tm, o_h, o_l, o_r, 1'b0});
    wr(7'h41, 8'hfe);
    wr(7'h42, 8'hf0);
    rdc(7'h41, 8'h3e);
    rdc(7'h42, 8'hf0);
    rdc(7'h10, 8'h00);
    cmp("outs", 8'hfe, {o_gh, o_gl, o_tx, o_tm, o_h, o_l, o_r, 1'b0});
    $display("regs done");
  endtask : t_regs
  task automatic t_loss(logic [7:0] cfg, int n);
    wr(7'h41, cfg);
    bits(1, 1);
    bits(n - 1, 0);
    cmp("los", 8'h00, {4'h0, o_los});
    bits(1, 0);
    cmp("los", 8'h0f, {4'h0, o_los});
    $display("loss done");
  endtask : t_loss
  task automatic t_mute_ict;
    {i_rx_pos, i_rx_neg} = 8'hff;
    repeat (2) @(negedge i_clk);
    cmp("pos", 8'hff, {o_p, o_v});
    wr(7'h41, 8'h06);
    @(negedge i_clk);
    cmp("pos", 8'h00, {o_p, o_v});
    bits(1, 1);
    @(negedge i_clk);
    cmp("pos", 8'hff, {o_p, o_v});
    wr(7'h41, 8'h01);
    cmp("oen", 8'h00, {7'h0, o_en});
    wr(7'h41, 8'h00);
    cmp("oen", 8'h01, {7'h0, o_en});
    i_in_circuit_test_n = 0;
    #1 cmp("oen", 8'h00, {7'h0, o_en});
    $display("mute done");
  endtask : t_mute_ict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  initial begin
    #1000000 n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(negedge i_clk);
    i_rst = 0;
    t_regs();
    t_loss(8'h00, 32);
    t_loss(8'h08, 175);
    t_loss(8'h02, 4096);
    t_mute_ict();
    report_and_stop();
  end
endmodule : tb_lgc_regs
